/* inc/dual_data_pointer_select_cfg.svh */
`ifndef DUAL_DATA_POINTER_SELECT_CFG_SVH
`define DUAL_DATA_POINTER_SELECT_CFG_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define PTR_LOW_IDX   8'h82
`define PTR_HIGH_IDX  8'h83
`define AUX_CTRL_IDX  8'ha2
`define PTR_LOW_ADDR  ({22'h000000, `PTR_LOW_IDX, 2'b00})
`define PTR_HIGH_ADDR ({22'h000000, `PTR_HIGH_IDX, 2'b00})
`define AUX_CTRL_ADDR ({22'h000000, `AUX_CTRL_IDX, 2'b00})

// ----------------------------------------
// Auxiliary control fields
// ----------------------------------------
`define AUX_SEL_BIT   0
`define AUX_ZERO_BIT  1
`define AUX_FLAG_BIT  3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PTR_BYTE_RESET 8'h00
`define PTR_RESET      16'h0000
`define AUX_RESET      8'h00
`define RDATA_RESET    32'h0000_0000

`endif

/* inc/dual_data_pointer_select_pkg.sv */
`default_nettype none

package dual_data_pointer_select_pkg;

  typedef enum logic {
    PH_IDLE,
    PH_DATA
  } bus_phase_t;

  typedef enum logic [1:0] {
    REG_NONE,
    REG_LOW,
    REG_HIGH,
    REG_AUX
  } reg_sel_t;

endpackage

`default_nettype wire

/* src/ahb_word_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dual_data_pointer_select_cfg.svh"

module ahb_word_port (
  input  wire logic        hclk,       // Bus clock
  input  wire logic        hresetn,    // Async reset, active low
  input  wire logic        hsel,       // Slave select
  input  wire logic [31:0] haddr,      // Address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write when high
  input  wire logic        hready,     // Bus ready
  input  wire logic [31:0] rd_value,   // Read word from register file
  output logic             hreadyout,  // Slave ready
  output logic             hresp,      // Always OKAY
  output logic      [31:0] hrdata,     // Read data
  output logic             in_data,    // Data phase wait cycle
  output logic      [31:0] acc_addr,   // Latched address
  output logic             acc_write   // Latched direction
);

  dual_data_pointer_select_pkg::bus_phase_t phase;
  logic accept;

  // One wait state lets a write land before any following read samples
  assign accept  = hsel && htrans[1] && hready;
  assign in_data = (phase == dual_data_pointer_select_pkg::PH_DATA);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase     <= dual_data_pointer_select_pkg::PH_IDLE;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= `RDATA_RESET;
      acc_addr  <= 32'h0000_0000;
      acc_write <= 1'b0;
    end else begin
      case (phase)
        dual_data_pointer_select_pkg::PH_IDLE: begin
          if (accept) begin
            phase     <= dual_data_pointer_select_pkg::PH_DATA;
            hreadyout <= 1'b0;
            acc_addr  <= haddr;
            acc_write <= hwrite;
          end
        end
        dual_data_pointer_select_pkg::PH_DATA: begin
          phase     <= dual_data_pointer_select_pkg::PH_IDLE;
          hreadyout <= 1'b1;
          hrdata    <= acc_write ? `RDATA_RESET : rd_value;
        end
        default: begin
          phase     <= dual_data_pointer_select_pkg::PH_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* src/data_pointer_pair.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dual_data_pointer_select_cfg.svh"

module data_pointer_pair (
  input  wire logic        hclk,        // Core clock
  input  wire logic        hresetn,     // Async reset, active low
  input  wire logic        cur_select,  // Pointer active now
  input  wire logic        next_select, // Pointer active next cycle
  input  wire logic        wr_low,      // Write low byte
  input  wire logic        wr_high,     // Write high byte
  input  wire logic [7:0]  wdata,       // Byte write data
  input  wire logic        load,        // Load whole pointer
  input  wire logic [15:0] load_value,  // Value for load
  input  wire logic        inc,         // 16-bit increment
  output logic      [15:0] ptr_zero,    // Stored pointer zero
  output logic      [15:0] ptr_one,     // Stored pointer one
  output logic      [15:0] active_ptr   // Registered active pointer
);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ptr
      logic [15:0] q;
      logic [15:0] nxt;
      // Only the selected entry moves; the other holds its value
      always_comb begin
        nxt = q;
        if (cur_select == 1'(g)) begin // R3
          if (wr_low) begin
            nxt[7:0] = wdata;
          end else if (wr_high) begin
            nxt[15:8] = wdata;
          end else if (load) begin
            nxt = load_value;
          end else if (inc) begin
            nxt = q + 16'h0001; // R10
          end
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          q <= `PTR_RESET; // R8
        end else begin
          q <= nxt; // R4
        end
      end
    end
  endgenerate

  assign ptr_zero = g_ptr[0].q; // R1
  assign ptr_one  = g_ptr[1].q;

  // Looks ahead so the address never lags a pointer change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_ptr <= `PTR_RESET;
    end else begin
      active_ptr <= next_select ? g_ptr[1].nxt : g_ptr[0].nxt; // R9
    end
  end

endmodule

`default_nettype wire

/* src/dual_data_pointer_select.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dual_data_pointer_select_cfg.svh"

// Functional notes
// (R1) Two independent 16-bit pointers, high:low bytes
// (R2) Select bit 0: zero picks pointer zero
// (R3) Byte registers reach the active pointer
// (R4) Inactive pointer keeps its value
// (R5) Auxiliary bit 1 reads zero, ignores writes
// (R6) Auxiliary increment toggles select only
// (R7) Bit 3 is a free user flag
// (R8) Both pointer bytes reset to zero
// (R9) Active pointer drives the memory address
// (R10) Pointer increment carries, active pointer only
module dual_data_pointer_select (
  input  wire logic        hclk,           // Core and bus clock
  input  wire logic        hresetn,        // Async reset, active low
  input  wire logic        hsel,           // AHB slave select
  input  wire logic [31:0] haddr,          // AHB address
  input  wire logic [1:0]  htrans,         // AHB transfer type
  input  wire logic        hwrite,         // AHB write
  input  wire logic [2:0]  hsize,          // AHB size, word only
  input  wire logic [31:0] hwdata,         // AHB write data
  input  wire logic        hready,         // AHB ready in
  output logic             hreadyout,      // AHB ready out
  output logic             hresp,          // AHB response
  output logic      [31:0] hrdata,         // AHB read data
  input  wire logic        core_ptr_inc,   // Increment active pointer
  input  wire logic        core_ptr_load,  // Load active pointer
  input  wire logic [15:0] core_load_value,// Value for load
  input  wire logic        core_aux_inc,   // Increment auxiliary register
  output logic      [15:0] ptr_addr,       // Active pointer address
  output logic             pointer_select, // Current select
  output logic             user_flag_two   // General flag
);

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  logic        in_data;
  logic [31:0] acc_addr;
  logic        acc_write;
  logic [31:0] rd_value;

  ahb_word_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .rd_value  (rd_value),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .in_data   (in_data),
    .acc_addr  (acc_addr),
    .acc_write (acc_write)
  );

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  dual_data_pointer_select_pkg::reg_sel_t acc_reg;
  logic wr_low;
  logic wr_high;
  logic wr_aux;
  logic rd_aux;

  // Unmapped words read zero and swallow writes
  always_comb begin
    case (acc_addr)
      `PTR_LOW_ADDR:  acc_reg = dual_data_pointer_select_pkg::REG_LOW;
      `PTR_HIGH_ADDR: acc_reg = dual_data_pointer_select_pkg::REG_HIGH;
      `AUX_CTRL_ADDR: acc_reg = dual_data_pointer_select_pkg::REG_AUX;
      default:        acc_reg = dual_data_pointer_select_pkg::REG_NONE;
    endcase
  end

  assign wr_low  = in_data && acc_write &&
                   (acc_reg == dual_data_pointer_select_pkg::REG_LOW);
  assign wr_high = in_data && acc_write &&
                   (acc_reg == dual_data_pointer_select_pkg::REG_HIGH);
  assign wr_aux  = in_data && acc_write &&
                   (acc_reg == dual_data_pointer_select_pkg::REG_AUX);
  assign rd_aux  = in_data && !acc_write &&
                   (acc_reg == dual_data_pointer_select_pkg::REG_AUX);

  // ----------------------------------------
  // Auxiliary control register
  // ----------------------------------------
  logic next_select;
  logic next_flag;
  localparam logic [7:0] aux_reset_value = `AUX_RESET;

  // Bus write beats a same-cycle core increment
  always_comb begin
    next_select = pointer_select;
    next_flag   = user_flag_two;
    if (wr_aux) begin
      next_select = hwdata[`AUX_SEL_BIT]; // R2
      next_flag   = hwdata[`AUX_FLAG_BIT]; // R7
    end else if (core_aux_inc) begin
      // Carry out of bit 0 dies in the fixed zero bit
      next_select = ~pointer_select; // R6
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pointer_select <= aux_reset_value[`AUX_SEL_BIT]; // R2
    end else begin
      pointer_select <= next_select;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      user_flag_two <= aux_reset_value[`AUX_FLAG_BIT];
    end else begin
      user_flag_two <= next_flag; // R7
    end
  end

  // ----------------------------------------
  // Pointer storage
  // ----------------------------------------
  logic [15:0] ptr_zero;
  logic [15:0] ptr_one;

  data_pointer_pair u_pair (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .cur_select  (pointer_select),
    .next_select (next_select),
    .wr_low      (wr_low),
    .wr_high     (wr_high),
    .wdata       (hwdata[7:0]),
    .load        (core_ptr_load),
    .load_value  (core_load_value),
    .inc         (core_ptr_inc),
    .ptr_zero    (ptr_zero),
    .ptr_one     (ptr_one),
    .active_ptr  (ptr_addr)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [7:0] aux_view;

  always_comb begin
    aux_view                = 8'h00;
    aux_view[`AUX_SEL_BIT]  = pointer_select;
    aux_view[`AUX_FLAG_BIT] = user_flag_two;
    aux_view[`AUX_ZERO_BIT] = 1'b0; // R5
  end

  always_comb begin
    case (acc_reg)
      dual_data_pointer_select_pkg::REG_LOW:
        rd_value = {24'h000000, ptr_addr[7:0]}; // R3
      dual_data_pointer_select_pkg::REG_HIGH:
        rd_value = {24'h000000, ptr_addr[15:8]};
      dual_data_pointer_select_pkg::REG_AUX:
        rd_value = {24'h000000, aux_view};
      default:
        rd_value = `RDATA_RESET;
    endcase
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic any_ptr_wr;
  assign any_ptr_wr = wr_low || wr_high;

  logic rd_low;
  logic rd_high;
  assign rd_low  = in_data && !acc_write &&
                   (acc_reg == dual_data_pointer_select_pkg::REG_LOW);
  assign rd_high = in_data && !acc_write &&
                   (acc_reg == dual_data_pointer_select_pkg::REG_HIGH);

  property p_addr_follows_select;
    @(posedge hclk) disable iff (!hresetn)
      ptr_addr == (pointer_select ? ptr_one : ptr_zero);
  endproperty
  a_addr_follows_select: assert property (p_addr_follows_select) // R9
    else $error("Address does not follow active pointer");

  property p_hold_one;
    @(posedge hclk) disable iff (!hresetn)
      !pointer_select |=> (ptr_one == $past(ptr_one));
  endproperty
  a_hold_one: assert property (p_hold_one) // R4
    else $error("Inactive pointer one changed");

  property p_hold_zero;
    @(posedge hclk) disable iff (!hresetn)
      pointer_select |=> (ptr_zero == $past(ptr_zero));
  endproperty
  a_hold_zero: assert property (p_hold_zero) // R4
    else $error("Inactive pointer zero changed");

  property p_select_write;
    @(posedge hclk) disable iff (!hresetn)
      wr_aux |=> (pointer_select == $past(hwdata[`AUX_SEL_BIT]));
  endproperty
  a_select_write: assert property (p_select_write) // R2
    else $error("Select bit not taken from write");

  property p_flag_write;
    @(posedge hclk) disable iff (!hresetn)
      wr_aux |=> (user_flag_two == $past(hwdata[`AUX_FLAG_BIT]));
  endproperty
  a_flag_write: assert property (p_flag_write) // R7
    else $error("User flag not taken from write");

  property p_aux_toggle;
    @(posedge hclk) disable iff (!hresetn)
      (core_aux_inc && !wr_aux) |=>
        (pointer_select != $past(pointer_select)) &&
        (user_flag_two == $past(user_flag_two));
  endproperty
  a_aux_toggle: assert property (p_aux_toggle) // R6
    else $error("Auxiliary increment did not toggle select only");

  property p_zero_bit_read;
    @(posedge hclk) disable iff (!hresetn)
      rd_aux |=> hreadyout && (hrdata[`AUX_ZERO_BIT] == 1'b0) &&
                 (hrdata[`AUX_SEL_BIT] == $past(pointer_select));
  endproperty
  a_zero_bit_read: assert property (p_zero_bit_read) // R5
    else $error("Auxiliary readback wrong");

  property p_low_write;
    @(posedge hclk) disable iff (!hresetn)
      (wr_low && !wr_aux) ##1 (pointer_select == $past(pointer_select)) |->
        (ptr_addr[7:0] == $past(hwdata[7:0])) &&
        (ptr_addr[15:8] == $past(ptr_addr[15:8]));
  endproperty
  a_low_write: assert property (p_low_write) // R3
    else $error("Low byte write missed the active pointer");

  property p_high_write;
    @(posedge hclk) disable iff (!hresetn)
      wr_high ##1 (pointer_select == $past(pointer_select)) |->
        (ptr_addr[15:8] == $past(hwdata[7:0])) &&
        (ptr_addr[7:0] == $past(ptr_addr[7:0]));
  endproperty
  a_high_write: assert property (p_high_write) // R3
    else $error("High byte write missed the active pointer");

  property p_ptr_inc;
    @(posedge hclk) disable iff (!hresetn)
      (core_ptr_inc && !core_ptr_load && !any_ptr_wr &&
       !wr_aux && !core_aux_inc) |=>
        (ptr_addr == $past(ptr_addr) + 16'h0001);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) // R10
    else $error("Pointer increment wrong");

  property p_reset_zero;
    @(posedge hclk)
      !hresetn |=> (ptr_zero == `PTR_RESET) && (ptr_one == `PTR_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero) // R8
    else $error("Pointers not zero after reset");

  property p_one_wait;
    @(posedge hclk) disable iff (!hresetn)
      in_data |-> !hreadyout ##1 hreadyout && !in_data && !hresp;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("Bus wait state not exactly one cycle");

  property p_sel_stable;
    @(posedge hclk) disable iff (!hresetn)
      (!wr_aux && !core_aux_inc) |=> $stable(pointer_select);
  endproperty
  a_sel_stable: assert property (p_sel_stable) // R2
    else $error("Select bit moved without a write or increment");

  property p_flag_stable;
    @(posedge hclk) disable iff (!hresetn)
      !wr_aux |=> $stable(user_flag_two);
  endproperty
  a_flag_stable: assert property (p_flag_stable) // R7
    else $error("User flag moved without a write");

  property p_load_active;
    @(posedge hclk) disable iff (!hresetn)
      (core_ptr_load && !any_ptr_wr && !wr_aux && !core_aux_inc) |=>
        (ptr_addr == $past(core_load_value));
  endproperty
  a_load_active: assert property (p_load_active) // R9
    else $error("Core load missed the active pointer");

  // ----------------------------------------
  // Readback and bus assertions
  // ----------------------------------------
  // Read data comes from the wait cycle, so a same-cycle strobe cannot tear it
  property p_low_read;
    @(posedge hclk) disable iff (!hresetn)
      rd_low |=> (hrdata == {24'h000000, $past(ptr_addr[7:0])});
  endproperty
  a_low_read: assert property (p_low_read) // R3
    else $error("Low byte read not from active pointer");

  property p_high_read;
    @(posedge hclk) disable iff (!hresetn)
      rd_high |=> (hrdata == {24'h000000, $past(ptr_addr[15:8])});
  endproperty
  a_high_read: assert property (p_high_read) // R3
    else $error("High byte read not from active pointer");

  property p_aux_read_view;
    @(posedge hclk) disable iff (!hresetn)
      rd_aux |=> (hrdata == {28'h0000000, $past(user_flag_two), 2'b00,
                             $past(pointer_select)});
  endproperty
  a_aux_read_view: assert property (p_aux_read_view) // R5
    else $error("Auxiliary read shows wrong bits");

  property p_write_reads_zero;
    @(posedge hclk) disable iff (!hresetn)
      (in_data && acc_write) |=> (hrdata == `RDATA_RESET);
  endproperty
  a_write_reads_zero: assert property (p_write_reads_zero)
    else $error("Read data not zero after a write");

  property p_accept_data;
    @(posedge hclk) disable iff (!hresetn)
      (hsel && htrans[1] && hready && hreadyout) |=>
        in_data && (acc_addr == $past(haddr)) && (acc_write == $past(hwrite));
  endproperty
  a_accept_data: assert property (p_accept_data)
    else $error("Address phase not latched");

  property p_reset_state;
    @(posedge hclk)
      !hresetn |=> !pointer_select && !user_flag_two && hreadyout &&
                   (ptr_addr == `PTR_RESET);
  endproperty
  a_reset_state: assert property (p_reset_state) // R8
    else $error("Outputs not at reset values");

endmodule

`default_nettype wire

/* testbench/core_strobe_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Processor side issuing pointer strobes
// ----------------------------------------
module core_strobe_model (
  input  wire logic        hclk,       // Core clock
  output logic             ptr_inc,    // Increment active pointer
  output logic             ptr_load,   // Load active pointer
  output logic      [15:0] load_value, // Value for load
  output logic             aux_inc     // Increment auxiliary register
);
  initial begin
    ptr_inc = 1'b0;
    ptr_load = 1'b0;
    aux_inc = 1'b0;
    load_value = 16'h0000;
  end

  // Kind bits: 0 inc, 1 load, 2 aux; gap idles first to act slowly
  task automatic pulse(input logic [2:0] kind, input logic [15:0] v, input int gap);
    repeat (gap) @(posedge hclk);
    @(posedge hclk);
    ptr_inc <= kind[0];
    ptr_load <= kind[1];
    aux_inc <= kind[2];
    load_value <= v;
    @(posedge hclk);
    ptr_inc <= 1'b0;
    ptr_load <= 1'b0;
    aux_inc <= 1'b0;
    // Released value is no longer valid, so show its inverse
    load_value <= ~v;
  endtask

  // Increments on consecutive edges, no idle between
  task automatic burst(input int n);
    @(posedge hclk);
    ptr_inc <= 1'b1;
    repeat (n) @(posedge hclk);
    ptr_inc <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* testbench/dual_data_pointer_select_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dual_data_pointer_select_cfg.svh"

module dual_data_pointer_select_tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        ptr_inc;
  logic        ptr_load;
  logic [15:0] load_value;
  logic        aux_inc;
  logic [15:0] ptr_addr;
  logic        pointer_select;
  logic        user_flag_two;
  logic [31:0] rd;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;

  dual_data_pointer_select dual_data_pointer_select_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .core_ptr_inc(ptr_inc), .core_ptr_load(ptr_load), .core_load_value(load_value),
    .core_aux_inc(aux_inc), .ptr_addr(ptr_addr), .pointer_select(pointer_select),
    .user_flag_two(user_flag_two)
  );

  core_strobe_model core_strobe_model_i (
    .hclk(hclk), .ptr_inc(ptr_inc), .ptr_load(ptr_load),
    .load_value(load_value), .aux_inc(aux_inc)
  );

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Hang guard, far above the roughly 115 cycles the tests need
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      test_done();
    end
  end

  // ----------------------------------------
  // Bus master
  // ----------------------------------------
  // Ready is looked at half a cycle early, where it is settled
  // No wait limit here; the hang guard ends a stuck bus
  task automatic wait_ready(output logic [31:0] d);
    @(negedge hclk);
    while (hreadyout !== 1'b1) begin
      @(negedge hclk);
    end
    d = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
    @(posedge hclk);
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready(d);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready(d);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] d;
    xfer(1'b1, a, v, d);
  endtask

  task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, rd);
    chk(name, rd, exp);
  endtask

  task automatic see(input logic [15:0] p, input logic s, input logic f);
    @(negedge hclk);
    chk("ptr_addr", {16'h0, ptr_addr}, {16'h0, p});
    chk("pointer_select", {31'h0, pointer_select}, {31'h0, s});
    chk("user_flag_two", {31'h0, user_flag_two}, {31'h0, f});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    see(16'h0000, 1'b0, 1'b0);
    rchk("low", `PTR_LOW_ADDR, 32'h0);
    rchk("high", `PTR_HIGH_ADDR, 32'h0);
    rchk("aux", `AUX_CTRL_ADDR, 32'h0);
    wr(`PTR_LOW_ADDR, 32'h0000_0034);
    wr(`PTR_HIGH_ADDR, 32'h0000_0012);
    see(16'h1234, 1'b0, 1'b0);
    wr(`AUX_CTRL_ADDR, 32'h0000_0001);
    see(16'h0000, 1'b1, 1'b0);
    rchk("low", `PTR_LOW_ADDR, 32'h0);
    wr(`PTR_LOW_ADDR, 32'h0000_00ff);
    wr(`PTR_HIGH_ADDR, 32'h0000_00ab);
    core_strobe_model_i.pulse(3'b001, 16'h0000, 0);
    see(16'hac00, 1'b1, 1'b0);
    rchk("high", `PTR_HIGH_ADDR, 32'h0000_00ac);
    core_strobe_model_i.burst(2);
    see(16'hac02, 1'b1, 1'b0);
    core_strobe_model_i.pulse(3'b100, 16'h0000, 3);
    see(16'h1234, 1'b0, 1'b0);
    rchk("low", `PTR_LOW_ADDR, 32'h0000_0034);
    core_strobe_model_i.pulse(3'b010, 16'hbeef, 0);
    see(16'hbeef, 1'b0, 1'b0);
    wr(`AUX_CTRL_ADDR, 32'h0000_00ff);
    see(16'hac02, 1'b1, 1'b1);
    rchk("aux", `AUX_CTRL_ADDR, 32'h0000_0009);
    // Software increment: read, add one, write back
    wr(`AUX_CTRL_ADDR, rd + 32'h1);
    rchk("aux", `AUX_CTRL_ADDR, 32'h0000_0008);
    see(16'hbeef, 1'b0, 1'b1);
    core_strobe_model_i.pulse(3'b100, 16'h0000, 0);
    see(16'hac02, 1'b1, 1'b1);
    wr(`AUX_CTRL_ADDR, 32'h0000_0000);
    see(16'hbeef, 1'b0, 1'b0);
    wr(32'h0000_0100, 32'hffff_ffff);
    rchk("unmapped", 32'h0000_0100, 32'h0);
    see(16'hbeef, 1'b0, 1'b0);
    // Strobe priority: bus wins in its commit cycle, load beats inc
    fork
      wr(`AUX_CTRL_ADDR, 32'h0000_0000);
      core_strobe_model_i.pulse(3'b100, 16'h0000, 1);
    join
    see(16'hbeef, 1'b0, 1'b0);
    core_strobe_model_i.pulse(3'b011, 16'h5a5a, 0);
    see(16'h5a5a, 1'b0, 1'b0);
    fork
      wr(`PTR_LOW_ADDR, 32'h0000_0011);
      core_strobe_model_i.pulse(3'b010, 16'h7777, 1);
    join
    see(16'h5a11, 1'b0, 1'b0);
    // Mid-run reset must clear the inactive pointer too
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    see(16'h0000, 1'b0, 1'b0);
    rchk("aux", `AUX_CTRL_ADDR, 32'h0);
    wr(`AUX_CTRL_ADDR, 32'h0000_0001);
    see(16'h0000, 1'b1, 1'b0);
    test_done();
  end
endmodule

`default_nettype wire
